/* shared/rsfm_pkg.sv */
// Shared constants, types and arithmetic helpers for the reading scale and filter menu block
package rsfm_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] A_STATUS  = 8'h00;
  localparam logic [7:0] A_CLEAR   = 8'h04;
  localparam logic [7:0] A_ENABLE  = 8'h08;
  localparam logic [7:0] A_OFFSET  = 8'h0C;
  localparam logic [7:0] A_MENU    = 8'h10;
  localparam logic [7:0] A_DISPLAY = 8'h14;
  localparam logic [7:0] A_CONFIG  = 8'h18;
  localparam logic [7:0] A_ANALOG  = 8'h1C;

  // Event bit positions in status, clear and enable
  localparam int EV_COMMIT = 0;
  localparam int EV_ERR    = 1;
  localparam int EV_SAMPLE = 2;
  localparam int NUM_EV    = 3;

  // Menu field positions in the menu status word
  localparam int MENU_HEAD_LSB  = 4;
  localparam int MENU_DIGIT_LSB = 8;
  localparam int MENU_LIT_BIT   = 16;

  // Last index of each menu choice
  localparam logic [1:0] LAST_HEAD   = 2'd3;
  localparam logic [2:0] LAST_DIGIT  = 3'd5;
  localparam logic [2:0] LAST_RADIX  = 3'd5;
  localparam logic [2:0] LAST_ROUND  = 3'd6;
  localparam logic [1:0] LAST_FIELD  = 2'd2;
  localparam logic [3:0] LAST_BCD    = 4'h9;

  // Factory scaling coordinates as six BCD digits
  localparam logic [23:0] DEF_IN1 = 24'h00_0000;
  localparam logic [23:0] DEF_RD1 = 24'h00_0000;
  localparam logic [23:0] DEF_IN2 = 24'h10_0000;
  localparam logic [23:0] DEF_RD2 = 24'h10_0000;

  // Display range for the reading offset check
  localparam logic signed [31:0] DISP_MAX = 32'sd999999;
  localparam logic signed [31:0] DISP_MIN = -32'sd99999;

  // Analog output sources
  localparam logic [1:0] AO_RAW    = 2'd0;
  localparam logic [1:0] AO_FILT   = 2'd1;
  localparam logic [1:0] AO_PEAK   = 2'd2;
  localparam logic [1:0] AO_VALLEY = 2'd3;

  typedef enum logic [2:0] {
    MS_RUN, MS_SCALE_HEAD, MS_SCALE_EDIT, MS_SCALE_COMMIT, MS_RADIX, MS_ROUND, MS_SMOOTH, MS_AVG
  } rsfm_menu_t;

  typedef struct packed {
    logic [2:0] radix;
    logic [2:0] round_idx;
    logic       smooth_type;
    logic       disp_src;
    logic [1:0] ao_src;
    logic [2:0] avg_idx;
  } rsfm_cfg_t;

  typedef struct packed {
    logic step;
    logic change;
    logic store;
  } rsfm_keys_t;

  // Factory settings: first radix place, count by 1, adaptive, filtered display and output, 64 samples
  localparam rsfm_cfg_t CFG_DEF = '{radix: 3'd0, round_idx: 3'd0, smooth_type: 1'b0, disp_src: 1'b1,
                                    ao_src: AO_FILT, avg_idx: 3'd6};

  // Six BCD digits to a binary count
  function automatic logic signed [31:0] bcd2bin(input logic [23:0] b);
    logic signed [31:0] acc;
    acc = 32'sd0;
    for (int i = 5; i >= 0; i--) begin
      acc = acc * 32'sd10 + $signed(32'(b[i*4+:4]));
    end
    return acc;
  endfunction

  // Rounding increment for a count-by choice
  function automatic logic signed [31:0] inc_of(input logic [2:0] idx);
    case (idx)
      3'd1:    return 32'sd2;
      3'd2:    return 32'sd5;
      3'd3:    return 32'sd10;
      3'd4:    return 32'sd20;
      3'd5:    return 32'sd50;
      3'd6:    return 32'sd100;
      default: return 32'sd1;
    endcase
  endfunction

  // Nearest multiple of inc, halves away from zero
  function automatic logic signed [31:0] round_to(input logic signed [31:0] v, input logic signed [31:0] inc);
    logic signed [31:0] half;
    half = inc / 32'sd2;
    if (v >= 32'sd0) begin
      return ((v + half) / inc) * inc;
    end
    return ((v - half) / inc) * inc;
  endfunction

endpackage

/* hw/rsfm_core.sv */
// Front-panel menu, two-point scaling, smoothing and count-by rounding for the panel meter
//
// Contract
// - Step cycles four headings; change opens value
// - Editing: step moves digit, change bumps it
// - Store while editing saves, goes next heading
// - Extra store after last value commits scaling
// - Scaling maps two input/reading coordinate pairs
// - Defaults zero and one hundred thousand
// - Step lights all digits; change moves radix
// - Store saves radix, goes to count-by
// - Error flag when offset exceeds display range
// - Count-by increments 1..100, default 1
// - Round to nearest increment, no delay
// - Store saves increment, goes to smoothing
// - Type 0 adaptive, 1 fixed moving average
// - Adaptive restarts averaging on fast change
// - Display source unfiltered 0, filtered 1
// - Analog source raw, filtered, peak, valley
// - Step cycles three fields; store commits all
// - Averaging count 1 to 128 in powers
module rsfm_core
  import rsfm_pkg::*;
#(
  parameter logic signed [31:0] ADAPT_STEP = 32'sd100
) (
  input  wire  logic               clk,
  input  wire  logic               nrst,
  input  wire  logic               psel,
  input  wire  logic               penable,
  input  wire  logic               pwrite,
  input  wire  logic [7:0]         paddr,
  input  wire  logic [31:0]        pwdata,
  output logic       [31:0]        prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire  logic               key_step_pin,
  input  wire  logic               key_change_pin,
  input  wire  logic               key_store_pin,
  input  wire  logic signed [31:0] raw_value,
  input  wire  logic               raw_valid,
  output logic signed [31:0]       disp_value,
  output logic                     disp_valid,
  output logic       [2:0]         radix_pos,
  output logic                     all_lit,
  output logic       [23:0]        edit_digits,
  output logic signed [31:0]       ao_value,
  output logic                     err01,
  output logic                     irq
);

  logic                rst_s1_reg, rst_n;
  logic [2:0]          key_s1_reg, key_s2_reg, key_prev_reg;
  rsfm_keys_t          key;
  rsfm_menu_t          menu_reg;
  logic [1:0]          head_reg;
  logic [2:0]          digit_reg;
  logic                lit_reg;
  logic [1:0]          field_reg;
  logic [23:0]         sc_reg [4];
  logic [23:0]         sc_stage [4];
  rsfm_cfg_t           cfg_reg, cfg_stage;
  logic                restart_pulse;
  logic signed [31:0]  offset_reg;
  logic [NUM_EV-1:0]   status_reg, enable_reg, ev;
  logic                err_reg, err_prev_reg;
  logic signed [31:0]  scaled_reg, peak_reg, valley_reg, filt;
  logic                scaled_vld_reg, filt_vld_reg;
  logic signed [31:0]  hist [128];
  logic [6:0]          wptr_reg;
  logic [7:0]          cur_n_reg, navg;
  logic signed [39:0]  sum_reg;
  logic signed [31:0]  i1, r1, i2, r2, scale_next, dev;
  logic signed [63:0]  num, den;
  logic                acc_wr;
  logic [31:0]         rd_data;
  logic                rd_err;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Reset release through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // Key pins: two-flop synchroniser then rising-edge detect
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_s1_reg   <= 3'b000;
      key_s2_reg   <= 3'b000;
      key_prev_reg <= 3'b000;
    end else begin
      key_s1_reg   <= {key_step_pin, key_change_pin, key_store_pin};
      key_s2_reg   <= key_s1_reg;
      key_prev_reg <= key_s2_reg;
    end
  end

  assign key = rsfm_keys_t'(key_s2_reg & ~key_prev_reg);

  // Menu walk: headings, digit edit, radix, count-by, smoothing, averaging count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      menu_reg      <= MS_RUN;
      head_reg      <= 2'd0;
      digit_reg     <= 3'd0;
      lit_reg       <= 1'b0;
      field_reg     <= 2'd0;
      cfg_reg       <= CFG_DEF;
      cfg_stage     <= CFG_DEF;
      restart_pulse <= 1'b0;
      sc_reg[0]     <= DEF_IN1;
      sc_reg[1]     <= DEF_RD1;
      sc_reg[2]     <= DEF_IN2;
      sc_reg[3]     <= DEF_RD2;
      for (int i = 0; i < 4; i++) begin
        sc_stage[i] <= 24'h00_0000;
      end
    end else begin
      restart_pulse <= 1'b0;
      case (menu_reg)
        MS_RUN: begin
          if (key.store) begin
            menu_reg  <= MS_SCALE_HEAD;
            head_reg  <= 2'd0;
            sc_stage  <= sc_reg;
            cfg_stage <= cfg_reg;
          end
        end
        MS_SCALE_HEAD: begin
          if (key.store) begin
            menu_reg <= MS_SCALE_COMMIT;
          end else if (key.change) begin
            menu_reg  <= MS_SCALE_EDIT;
            digit_reg <= 3'd0;
          end else if (key.step) begin
            head_reg <= head_reg + 2'd1;
          end
        end
        MS_SCALE_EDIT: begin
          if (key.store) begin
            if (head_reg == LAST_HEAD) begin
              menu_reg <= MS_SCALE_COMMIT;
            end else begin
              menu_reg <= MS_SCALE_HEAD;
              head_reg <= head_reg + 2'd1;
            end
          end else if (key.change) begin
            if (sc_stage[head_reg][digit_reg*4+:4] >= LAST_BCD) begin
              sc_stage[head_reg][digit_reg*4+:4] <= 4'h0;
            end else begin
              sc_stage[head_reg][digit_reg*4+:4] <= sc_stage[head_reg][digit_reg*4+:4] + 4'h1;
            end
          end else if (key.step) begin
            digit_reg <= (digit_reg == LAST_DIGIT) ? 3'd0 : digit_reg + 3'd1;
          end
        end
        MS_SCALE_COMMIT: begin
          if (key.store) begin
            sc_reg   <= sc_stage;
            menu_reg <= MS_RADIX;
            lit_reg  <= 1'b0;
          end
        end
        MS_RADIX: begin
          if (key.store) begin
            cfg_reg.radix <= cfg_stage.radix;
            menu_reg      <= MS_ROUND;
          end else if (key.change) begin
            cfg_stage.radix <= (cfg_stage.radix == LAST_RADIX) ? 3'd0 : cfg_stage.radix + 3'd1;
          end else if (key.step) begin
            lit_reg <= ~lit_reg;
          end
        end
        MS_ROUND: begin
          if (key.store) begin
            cfg_reg.round_idx <= cfg_stage.round_idx;
            menu_reg          <= MS_SMOOTH;
            field_reg         <= 2'd0;
          end else if (key.step || key.change) begin
            cfg_stage.round_idx <= (cfg_stage.round_idx == LAST_ROUND) ? 3'd0 : cfg_stage.round_idx + 3'd1;
          end
        end
        MS_SMOOTH: begin
          if (key.store) begin
            cfg_reg.smooth_type <= cfg_stage.smooth_type;
            cfg_reg.disp_src    <= cfg_stage.disp_src;
            cfg_reg.ao_src      <= cfg_stage.ao_src;
            restart_pulse       <= 1'b1;
            menu_reg            <= MS_AVG;
          end else if (key.change) begin
            case (field_reg)
              2'd0:    cfg_stage.smooth_type <= ~cfg_stage.smooth_type;
              2'd1:    cfg_stage.disp_src <= ~cfg_stage.disp_src;
              default: cfg_stage.ao_src <= cfg_stage.ao_src + 2'd1;
            endcase
          end else if (key.step) begin
            field_reg <= (field_reg == LAST_FIELD) ? 2'd0 : field_reg + 2'd1;
          end
        end
        default: begin
          if (key.store) begin
            cfg_reg.avg_idx <= cfg_stage.avg_idx;
            restart_pulse   <= 1'b1;
            menu_reg        <= MS_RUN;
          end else if (key.step || key.change) begin
            cfg_stage.avg_idx <= cfg_stage.avg_idx + 3'd1;
          end
        end
      endcase
    end
  end

  step_head_a: assert property ((menu_reg == MS_SCALE_HEAD) && key.step && !key.change && !key.store
                                |=> head_reg == $past(head_reg) + 2'd1) else $error("heading did not advance");
  edit_next_a: assert property ((menu_reg == MS_SCALE_EDIT) && key.store && head_reg != LAST_HEAD
                                |=> menu_reg == MS_SCALE_HEAD && head_reg == $past(head_reg) + 2'd1)
    else $error("store in edit did not move on");
  scale_commit_a: assert property ((menu_reg == MS_SCALE_COMMIT) && key.store
                                   |=> menu_reg == MS_RADIX && sc_reg[3] == $past(sc_stage[3]))
    else $error("scaling not committed");
  radix_store_a: assert property ((menu_reg == MS_RADIX) && key.store
                                  |=> menu_reg == MS_ROUND && cfg_reg.radix == $past(cfg_stage.radix))
    else $error("radix not stored");
  radix_range_a: assert property (cfg_stage.radix <= LAST_RADIX && cfg_reg.radix <= LAST_RADIX)
    else $error("radix out of range");
  round_store_a: assert property ((menu_reg == MS_ROUND) && key.store
                                  |=> menu_reg == MS_SMOOTH ##1 menu_reg == MS_SMOOTH || key.store)
    else $error("count-by store did not advance");
  smooth_store_a: assert property ((menu_reg == MS_SMOOTH) && key.store
                                   |=> menu_reg == MS_AVG && restart_pulse && cfg_reg.ao_src == $past(cfg_stage.ao_src))
    else $error("smoothing settings not committed");

  // Two-point scaling of the raw reading
  always_comb begin
    i1  = bcd2bin(sc_reg[0]);
    r1  = bcd2bin(sc_reg[1]);
    i2  = bcd2bin(sc_reg[2]);
    r2  = bcd2bin(sc_reg[3]);
    num = (64'(raw_value) - 64'(i1)) * (64'(r2) - 64'(r1));
    den = 64'(i2) - 64'(i1);
    if (den == 64'sd0) begin
      scale_next = r1; // Degenerate pair holds the first reading
    end else begin
      scale_next = 32'(64'(r1) + num / den);
    end
  end

  // Scaled sample, peak and valley registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scaled_reg     <= 32'sh0000_0000;
      scaled_vld_reg <= 1'b0;
      peak_reg       <= 32'sh8000_0000;
      valley_reg     <= 32'sh7FFF_FFFF;
    end else begin
      scaled_vld_reg <= raw_valid;
      if (raw_valid) begin
        scaled_reg <= scale_next;
        if (scale_next > peak_reg) begin
          peak_reg <= scale_next;
        end
        if (scale_next < valley_reg) begin
          valley_reg <= scale_next;
        end
      end
    end
  end

  // Sample history for the moving window; no reset needed, only written slots are read
  always_ff @(posedge clk) begin
    if (scaled_vld_reg) begin
      hist[wptr_reg] <= scaled_reg;
    end
  end

  assign navg = 8'd1 << cfg_reg.avg_idx;
  assign filt = 32'(sum_reg / $signed({32'd0, cur_n_reg}));
  assign dev  = (scaled_reg > filt) ? scaled_reg - filt : filt - scaled_reg;

  // Window sum; the adaptive mode drops to one sample on a fast move
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_reg     <= 7'd0;
      cur_n_reg    <= 8'd0;
      sum_reg      <= 40'sd0;
      filt_vld_reg <= 1'b0;
    end else begin
      filt_vld_reg <= scaled_vld_reg;
      if (scaled_vld_reg) begin
        wptr_reg <= wptr_reg + 7'd1;
        if (restart_pulse || cur_n_reg == 8'd0 || cur_n_reg > navg ||
            (!cfg_reg.smooth_type && dev > ADAPT_STEP)) begin
          sum_reg   <= 40'(scaled_reg);
          cur_n_reg <= 8'd1;
        end else if (cur_n_reg < navg) begin
          sum_reg   <= sum_reg + 40'(scaled_reg);
          cur_n_reg <= cur_n_reg + 8'd1;
        end else begin
          sum_reg <= sum_reg + 40'(scaled_reg) - 40'(hist[7'(wptr_reg - navg[6:0])]);
        end
      end else if (restart_pulse) begin
        cur_n_reg <= 8'd0;
      end
    end
  end

  avg_bound_a: assert property (cur_n_reg <= 8'd128 && (cur_n_reg <= navg || $past(restart_pulse)
                                || $past(cfg_reg.avg_idx) != cfg_reg.avg_idx || !filt_vld_reg))
    else $error("average count beyond selection");

  // Display and analog output stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      disp_value <= 32'sh0000_0000;
      disp_valid <= 1'b0;
      ao_value   <= 32'sh0000_0000;
    end else begin
      disp_valid <= filt_vld_reg;
      if (filt_vld_reg) begin
        disp_value <= round_to(cfg_reg.disp_src ? filt : scaled_reg, inc_of(cfg_reg.round_idx));
        case (cfg_reg.ao_src)
          AO_RAW:  ao_value <= scaled_reg;
          AO_FILT: ao_value <= filt;
          AO_PEAK: ao_value <= peak_reg;
          default: ao_value <= valley_reg;
        endcase
      end
    end
  end

  raw_disp_a: assert property (filt_vld_reg && !cfg_reg.disp_src |=> disp_valid &&
                               32'sd2 * (disp_value - $past(scaled_reg)) <= inc_of($past(cfg_reg.round_idx)) &&
                               32'sd2 * ($past(scaled_reg) - disp_value) <= inc_of($past(cfg_reg.round_idx)))
    else $error("unfiltered display off the nearest step");
  round_mult_a: assert property (disp_valid |-> disp_value % inc_of(cfg_reg.round_idx) == 32'sd0)
    else $error("display not a count-by multiple");

  assign radix_pos   = cfg_reg.radix;
  assign all_lit     = lit_reg && (menu_reg == MS_RADIX);
  assign edit_digits = sc_stage[head_reg];

  // Offset range check and its error flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_reg      <= 1'b0;
      err_prev_reg <= 1'b0;
    end else begin
      err_reg      <= (offset_reg > DISP_MAX) || (offset_reg < DISP_MIN);
      err_prev_reg <= err_reg; // Previous flag for the rising-edge event
    end
  end

  assign err01 = err_reg;

  err_flag_a: assert property (##1 err01 == $past((offset_reg > DISP_MAX) || (offset_reg < DISP_MIN)))
    else $error("offset error flag wrong");

  // Events: commit of smoothing or averaging settings, error rising, new displayed value
  assign ev[EV_COMMIT] = restart_pulse;
  assign ev[EV_ERR]    = err_reg && !err_prev_reg;
  assign ev[EV_SAMPLE] = disp_valid;
  assign acc_wr        = psel && penable && pwrite;

  // Writable registers and sticky status; a new event wins over a clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= '0;
      enable_reg <= '0;
      offset_reg <= 32'sh0000_0000;
    end else begin
      if (acc_wr && paddr == A_ENABLE) begin
        enable_reg <= pwdata[NUM_EV-1:0];
      end
      if (acc_wr && paddr == A_OFFSET) begin
        offset_reg <= $signed(pwdata);
      end
      if (acc_wr && paddr == A_CLEAR) begin
        status_reg <= (status_reg & ~pwdata[NUM_EV-1:0]) | ev;
      end else begin
        status_reg <= status_reg | ev;
      end
    end
  end

  assign irq = |(status_reg & enable_reg);

  irq_level_a: assert property (##1 irq == |($past(status_reg | ev) & $past(enable_reg)) || $past(acc_wr))
    else $error("interrupt level wrong");

  // Read decode and unmapped answer
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    if (paddr == A_STATUS) begin
      rd_data = 32'(status_reg);
    end else if (paddr == A_CLEAR) begin
      rd_data = 32'h0000_0000;
    end else if (paddr == A_ENABLE) begin
      rd_data = 32'(enable_reg);
    end else if (paddr == A_OFFSET) begin
      rd_data = offset_reg;
    end else if (paddr == A_MENU) begin
      rd_data = 32'(menu_reg) | (32'(head_reg) << MENU_HEAD_LSB) | (32'(digit_reg) << MENU_DIGIT_LSB)
              | (32'(all_lit) << MENU_LIT_BIT);
    end else if (paddr == A_DISPLAY) begin
      rd_data = disp_value;
    end else if (paddr == A_CONFIG) begin
      rd_data = 32'(cfg_reg);
    end else if (paddr == A_ANALOG) begin
      rd_data = ao_value;
    end else begin
      rd_err = 1'b1;
    end
  end

  // Read data and error captured in the setup cycle, answered in the access cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_data;
      pslverr <= rd_err;
    end
  end

  assign pready = 1'b1;

endmodule

/* tb/rsfm_operator.sv */
// Operator model that presses the three front-panel keys
module rsfm_operator (
  input  wire logic clk,
  output logic      key_step_pin,
  output logic      key_change_pin,
  output logic      key_store_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Keys idle low
  initial begin
    key_step_pin = 1'b0;
    key_change_pin = 1'b0;
    key_store_pin = 1'b0;
  end
  // Each press is held four cycles, then released four cycles
  task automatic press(input int k, input int n = 1);
    repeat (n) begin
      @(posedge clk);
      if (k == 0) key_step_pin <= 1'b1;
      else if (k == 1) key_change_pin <= 1'b1;
      else key_store_pin <= 1'b1;
      repeat (4) @(posedge clk);
      {key_step_pin, key_change_pin, key_store_pin} <= 3'b000;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule

/* tb/rsfm_core_bench.sv */
// Self-checking bench for the menu, scaling and rounding block
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module rsfm_core_bench
  import rsfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, psel, penable, pwrite, raw_valid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, lf;
  logic pready, pslverr, perr, disp_valid, all_lit, err01, irq, ks, kc, kt;
  logic signed [31:0] raw_value, disp_value, ao_value;
  logic [2:0] radix_pos;
  logic [23:0] edit_digits;
  int error_cnt, check_count, cyc;
  longint v, sc, vmin, vmax, fa;
  longint q[$];
  always #20 clk = ~clk;
  rsfm_operator op_u (.clk(clk), .key_step_pin(ks), .key_change_pin(kc), .key_store_pin(kt));
  rsfm_core dut_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .key_step_pin(ks),
    .key_change_pin(kc), .key_store_pin(kt), .raw_value(raw_value), .raw_valid(raw_valid),
    .disp_value(disp_value), .disp_valid(disp_valid), .radix_pos(radix_pos), .all_lit(all_lit),
    .edit_digits(edit_digits), .ao_value(ao_value), .err01(err01), .irq(irq));
  // Next pseudo-random word
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Nearest multiple of ten, halves away from zero
  function automatic longint near10(input longint x);
    return (x >= 0) ? ((x + 5) / 10) * 10 : ((x - 5) / 10) * 10;
  endfunction
  // One raw sample, then wait until the displayed result stands
  task automatic feed(input longint x);
    @(posedge clk);
    raw_value <= 32'(x);
    raw_valid <= 1'b1;
    @(posedge clk);
    raw_valid <= 1'b0;
    for (int k = 0; k < 8 && disp_valid !== 1'b1; k++) @(negedge clk);
    `CHK(disp_valid, 1'b1)
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Read a register and compare the masked word
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd & m, e)
  endtask
  // Closing report
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    {clk, nrst, psel, penable, pwrite, raw_valid} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    raw_value = 32'sh0000_0000;
    lf = 32'h0000_3464;
    vmin = 64'sd999999999;
    vmax = -64'sd999999999;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk(A_CONFIG, 32'h0000_002E, 32'h0000_1FFF);
    `CHK(edit_digits, DEF_IN1)
    apb(1'b0, 8'h40, 32'h0000_0000);
    `CHK(perr, 1'b1)
    apb(1'b1, A_ENABLE, 32'h0000_0007);
    rdchk(A_ENABLE, 32'h0000_0007, 32'h0000_0007);
    $display("Test defaults and bus done");
    op_u.press(2);
    op_u.press(1);
    rdchk(A_MENU, 32'h0000_0002, 32'h0000_0737);
    op_u.press(1, 2);
    op_u.press(0);
    op_u.press(1);
    `CHK(edit_digits, 24'h00_0012)
    rdchk(A_MENU, 32'h0000_0102, 32'h0000_0737);
    op_u.press(2);
    rdchk(A_MENU, 32'h0000_0111, 32'h0000_0737);
    op_u.press(0);
    rdchk(A_MENU, 32'h0000_0121, 32'h0000_0737);
    op_u.press(2, 2);
    rdchk(A_MENU, 32'h0000_0004, 32'h0000_0007);
    op_u.press(0);
    `CHK(all_lit, 1'b1)
    op_u.press(1, 2);
    op_u.press(2);
    `CHK(radix_pos, 3'd2)
    rdchk(A_MENU, 32'h0000_0005, 32'h0000_0007);
    op_u.press(1, 3);
    op_u.press(2);
    rdchk(A_MENU, 32'h0000_0006, 32'h0000_0007);
    op_u.press(1);
    op_u.press(0);
    op_u.press(1);
    op_u.press(0);
    op_u.press(1, 2);
    op_u.press(2);
    rdchk(A_MENU, 32'h0000_0007, 32'h0000_0007);
    op_u.press(1, 2);
    op_u.press(2);
    rdchk(A_CONFIG, 32'h0000_09D8, 32'h0000_1FFF);
    `CHK(irq, 1'b1)
    $display("Test menu walk done");
    // Scaled by input 12 to 100000, one-sample window, count by 10, valley output
    for (int i = 0; i < 12; i++) begin
      lf = lfsr(lf);
      v = longint'(lf % 32'd100000);
      sc = (v - 12) * 100000 / 99988;
      if (sc < vmin) vmin = sc;
      if (sc > vmax) vmax = sc;
      feed(v);
      `CHK(disp_value, 32'(near10(sc)))
      `CHK(ao_value, 32'(vmin))
    end
    $display("Test data path done");
    // Second walk: adaptive, filtered display, peak output, two-sample window
    op_u.press(2, 5);
    op_u.press(1);
    op_u.press(0);
    op_u.press(1);
    op_u.press(0);
    op_u.press(1, 3);
    op_u.press(2);
    op_u.press(1);
    op_u.press(2);
    rdchk(A_CONFIG, 32'h0000_09B1, 32'h0000_1FFF);
    // Close samples average, far jumps restart the adaptive window
    for (int i = 0; i < 10; i++) begin
      lf = lfsr(lf);
      v = (i < 5) ? 64'sd50000 + longint'(lf % 32'd40) : longint'(lf % 32'd100000);
      sc = (v - 12) * 100000 / 99988;
      if (sc > vmax) vmax = sc;
      fa = 0;
      foreach (q[j]) fa += q[j];
      if (q.size() == 0 || sc - fa / q.size() > 100 || fa / q.size() - sc > 100) q.delete();
      q.push_back(sc);
      if (q.size() > 2) void'(q.pop_front());
      fa = 0;
      foreach (q[j]) fa += q[j];
      feed(v);
      `CHK(disp_value, 32'(near10(fa / q.size())))
      `CHK(ao_value, 32'(vmax))
    end
    $display("Test filtered path done");
    apb(1'b1, A_CLEAR, 32'h0000_0007);
    rdchk(A_STATUS, 32'h0000_0000, 32'h0000_0007);
    `CHK(irq, 1'b0)
    apb(1'b1, A_OFFSET, 32'd1000000);
    rdchk(A_OFFSET, 32'd1000000, 32'hFFFF_FFFF);
    `CHK(err01, 1'b1)
    rdchk(A_STATUS, 32'h0000_0002, 32'h0000_0002);
    `CHK(irq, 1'b1)
    apb(1'b1, A_ENABLE, 32'h0000_0000);
    @(negedge clk);
    `CHK(irq, 1'b0)
    apb(1'b1, A_OFFSET, 32'd999999);
    apb(1'b0, A_STATUS, 32'h0000_0000);
    `CHK(err01, 1'b0)
    $display("Test offset range and interrupt done");
    give_verdict();
  end
endmodule
